// >>> core/motion_regs_pkg.sv
package motion_regs_pkg;

   // ***********************************************************
   // Register addresses
   // ***********************************************************
   localparam logic [4:0] ADDR_ELEC_POS = 5'h02;
   localparam logic [4:0] ADDR_MARK = 5'h03;
   localparam logic [4:0] ADDR_SPEED = 5'h04;
   localparam logic [4:0] ADDR_RAMP_UP = 5'h05;
   localparam logic [4:0] ADDR_RAMP_DOWN = 5'h06;
   localparam logic [4:0] ADDR_VEL_CEIL = 5'h07;
   localparam logic [4:0] ADDR_VEL_FLOOR = 5'h08;
   localparam logic [4:0] ADDR_TORQUE_FIRST = 5'h09;
   localparam logic [4:0] ADDR_TORQUE_LAST = 5'h0C;
   localparam logic [4:0] ADDR_FS_THRESH = 5'h15;

   // ***********************************************************
   // Widths and field positions
   // ***********************************************************
   localparam int ADDR_W = 5;
   localparam int DATA_W = 22;
   localparam int ELEC_W = 9;
   localparam int MARK_W = 22;
   localparam int SPEED_W = 20;
   localparam int RATE_W = 12;
   localparam int CEIL_W = 10;
   localparam int FLOOR_W = 13;
   localparam int FLOOR_VAL_W = 12;
   localparam int FS_W = 11;
   localparam int FS_VAL_W = 10;
   localparam int FS_BOOST_BIT = 10;
   localparam int TORQUE_W = 7;
   localparam int ACC_W = 32;
   // Internal velocity keeps 12 extra bits so 0.40 rates add to 0.28 speed
   localparam int VEL_EXTRA = 12;
   localparam int CEIL_SHIFT = 10;
   localparam int FLOOR_SHIFT = 4;

   // ***********************************************************
   // Reset values
   // ***********************************************************
   localparam logic [ELEC_W-1:0] RST_ELEC_POS = 9'h000;
   localparam logic [MARK_W-1:0] RST_MARK = 22'h000000;
   localparam logic [RATE_W-1:0] RST_RATE = 12'h08A;
   localparam logic [CEIL_W-1:0] RST_VEL_CEIL = 10'h041;
   localparam logic [FLOOR_VAL_W-1:0] RST_VEL_FLOOR = 12'h000;
   localparam logic [FS_W-1:0] RST_FS_THRESH = 11'h027;
   localparam logic [TORQUE_W-1:0] RST_TORQUE = 7'h29;
   // One sixteenth of a step in electrical position counts
   localparam logic [ELEC_W-1:0] ELEC_USTEP_INC = 9'h008;
   localparam logic [FS_W-1:0] FS_HALF_COUNT = 11'h200;

   // ***********************************************************
   // Time base
   // ***********************************************************
   localparam int CLK_PERIOD_NS = 25;
   localparam int TICK_NS = 250;
   localparam int TICK_CYC = (TICK_NS / CLK_PERIOD_NS < 1) ? 1 : TICK_NS / CLK_PERIOD_NS;
   localparam int TICK_CNT_W = 4;

   // Order matches the torque register order
   typedef enum logic [1:0] {MOT_STOPPED, MOT_CRUISE, MOT_ACCEL, MOT_DECEL} motion_e;

endpackage

// >>> core/profile_if.sv
`timescale 1ns/10ps
`default_nettype none
interface profile_if;
   import motion_regs_pkg::*;
   logic tick;
   logic run_req;
   logic [RATE_W-1:0] ramp_up;
   logic [RATE_W-1:0] ramp_down;
   logic [CEIL_W-1:0] ceiling;
   logic [FLOOR_VAL_W-1:0] floor_val;
   logic [SPEED_W-1:0] speed;
   motion_e state;
   modport ctrl (output tick, output run_req, output ramp_up, output ramp_down, output ceiling,
                 output floor_val, input speed, input state);
   modport gen (input tick, input run_req, input ramp_up, input ramp_down, input ceiling,
                input floor_val, output speed, output state);
endinterface
`default_nettype wire

// >>> core/torque_store.sv
`timescale 1ns/10ps
`default_nettype none
module torque_store
   import motion_regs_pkg::*;
#(
   parameter int DEPTH = 4,
   parameter int WIDTH = TORQUE_W
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic wr_en,
   input wire logic [$clog2(DEPTH)-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic [$clog2(DEPTH)-1:0] rd_a_addr,
   output logic [WIDTH-1:0] rd_a_data,
   input wire logic [$clog2(DEPTH)-1:0] rd_b_addr,
   output logic [WIDTH-1:0] rd_b_data
);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [WIDTH-1:0] nxt_mem [DEPTH];

   always_comb begin
      for (int i = 0; i < DEPTH; i++) begin
         nxt_mem[i] = (wr_en && wr_addr == i[$clog2(DEPTH)-1:0]) ? wr_data : mem_ff[i];
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_ff[i] <= RST_TORQUE;
         end
         rd_a_data <= '0;
         rd_b_data <= '0;
      end else begin
         mem_ff <= nxt_mem;
         rd_a_data <= mem_ff[rd_a_addr];
         rd_b_data <= mem_ff[rd_b_addr];
      end
   end
endmodule
`default_nettype wire

// >>> core/velocity_ramp.sv
`timescale 1ns/10ps
`default_nettype none
module velocity_ramp
   import motion_regs_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   profile_if.gen pif
);
   motion_e state_ff, nxt_state;
   logic [ACC_W-1:0] vel_ff, nxt_vel;
   logic [ACC_W:0] sum;
   logic [ACC_W-1:0] ceil_v, floor_v;

   assign pif.speed = vel_ff[ACC_W-1:VEL_EXTRA];
   assign pif.state = state_ff;

   always_comb begin
      ceil_v = ACC_W'({pif.ceiling, CEIL_SHIFT'(0)}) << VEL_EXTRA;
      floor_v = ACC_W'({pif.floor_val, FLOOR_SHIFT'(0)}) << VEL_EXTRA;
      nxt_state = state_ff;
      nxt_vel = vel_ff;
      sum = '0;
      if (pif.tick) begin
         case (state_ff)
            MOT_STOPPED: begin
               if (pif.run_req) begin
                  nxt_vel = floor_v;
                  nxt_state = MOT_ACCEL;
               end
            end
            MOT_ACCEL: begin
               sum = {1'b0, vel_ff} + (ACC_W+1)'(pif.ramp_up);
               nxt_vel = (sum[ACC_W] || sum[ACC_W-1:0] >= ceil_v) ? ceil_v : sum[ACC_W-1:0];
               if (nxt_vel < floor_v) begin
                  nxt_vel = floor_v;
               end
               if (!pif.run_req) begin
                  nxt_state = MOT_DECEL;
               end else if (nxt_vel >= ceil_v) begin
                  nxt_state = MOT_CRUISE;
               end
            end
            MOT_CRUISE: begin
               if (!pif.run_req) begin
                  nxt_state = MOT_DECEL;
               end
            end
            MOT_DECEL: begin
               sum = {1'b0, vel_ff} - (ACC_W+1)'(pif.ramp_down);
               if (pif.run_req) begin
                  nxt_state = MOT_ACCEL;
               end else if (sum[ACC_W] || sum[ACC_W-1:0] <= floor_v) begin
                  // Reaching the floor ends the move
                  nxt_vel = '0;
                  nxt_state = MOT_STOPPED;
               end else begin
                  nxt_vel = sum[ACC_W-1:0];
               end
            end
            default: nxt_state = MOT_STOPPED;
         endcase
      end
      // Ceiling may be lowered at any time, so it clamps last and on every cycle
      if (nxt_vel > ceil_v) begin
         nxt_vel = ceil_v;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         state_ff <= MOT_STOPPED;
         vel_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         vel_ff <= nxt_vel;
      end
   end
endmodule
`default_nettype wire

// >>> core/stepper_motion_profile_regs.sv
`timescale 1ns/10ps
`default_nettype none
module stepper_motion_profile_regs
   import motion_regs_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   output logic [DATA_W-1:0] reg_rdata,
   output logic reg_rvalid,
   output logic cmd_error,
   input wire logic run_req,
   input wire logic ustep_adv,
   input wire logic ustep_dir,
   output logic [ELEC_W-1:0] electrical_position,
   output logic elec_pos_load,
   output logic [SPEED_W-1:0] current_velocity,
   output logic [1:0] motion_state,
   output logic full_step_drive,
   output logic boost_drive,
   output logic [TORQUE_W-1:0] torque_ref
);

   // ***********************************************************
   // Tick generator
   // ***********************************************************
   logic [TICK_CNT_W-1:0] tick_cnt_ff, nxt_tick_cnt;
   logic tick_ff, nxt_tick;

   always_comb begin
      nxt_tick = 1'b0;
      if (tick_cnt_ff == TICK_CNT_W'(TICK_CYC - 1)) begin
         nxt_tick_cnt = '0;
         nxt_tick = 1'b1;
      end else begin
         nxt_tick_cnt = tick_cnt_ff + 1'b1;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         tick_cnt_ff <= '0;
         tick_ff <= 1'b0;
      end else begin
         tick_cnt_ff <= nxt_tick_cnt;
         tick_ff <= nxt_tick;
      end
   end

   // ***********************************************************
   // Profile generator
   // ***********************************************************
   profile_if pif ();
   logic running;

   velocity_ramp u_ramp (
      .mclk(mclk),
      .reset(reset),
      .pif(pif.gen)
   );

   assign running = (pif.state != MOT_STOPPED);

   // ***********************************************************
   // Register writes
   // ***********************************************************
   logic [ELEC_W-1:0] elec_pos_ff, nxt_elec_pos;
   logic [MARK_W-1:0] mark_ff, nxt_mark;
   logic [RATE_W-1:0] ramp_up_ff, nxt_ramp_up;
   logic [RATE_W-1:0] ramp_down_ff, nxt_ramp_down;
   logic [CEIL_W-1:0] ceil_ff, nxt_ceil;
   logic [FLOOR_VAL_W-1:0] floor_ff, nxt_floor;
   logic [FS_W-1:0] fs_ff, nxt_fs;
   logic cmd_error_ff, nxt_cmd_error;
   logic elec_load_ff, nxt_elec_load;
   logic torque_wr;
   logic [1:0] torque_wr_idx;
   logic is_torque_addr;

   assign is_torque_addr = (reg_addr >= ADDR_TORQUE_FIRST) && (reg_addr <= ADDR_TORQUE_LAST);

   always_comb begin
      nxt_elec_pos = elec_pos_ff;
      nxt_mark = mark_ff;
      nxt_ramp_up = ramp_up_ff;
      nxt_ramp_down = ramp_down_ff;
      nxt_ceil = ceil_ff;
      nxt_floor = floor_ff;
      nxt_fs = fs_ff;
      nxt_cmd_error = 1'b0;
      nxt_elec_load = 1'b0;
      torque_wr = 1'b0;
      torque_wr_idx = 2'(reg_addr - ADDR_TORQUE_FIRST);
      // Phase generator advances the position by one sixteenth step
      if (ustep_adv) begin
         nxt_elec_pos = ustep_dir ? elec_pos_ff + ELEC_USTEP_INC : elec_pos_ff - ELEC_USTEP_INC;
      end
      if (reg_wr) begin
         case (reg_addr)
            ADDR_ELEC_POS: begin
               if (running) begin
                  nxt_cmd_error = 1'b1;
               end else begin
                  // Written value wins over a same-cycle advance
                  nxt_elec_pos = reg_wdata[ELEC_W-1:0];
                  nxt_elec_load = 1'b1;
               end
            end
            ADDR_MARK: nxt_mark = reg_wdata[MARK_W-1:0];
            ADDR_SPEED: nxt_cmd_error = 1'b1;
            ADDR_RAMP_UP: begin
               if (running) begin
                  nxt_cmd_error = 1'b1;
               end else begin
                  nxt_ramp_up = reg_wdata[RATE_W-1:0];
               end
            end
            ADDR_RAMP_DOWN: begin
               if (running) begin
                  nxt_cmd_error = 1'b1;
               end else begin
                  nxt_ramp_down = reg_wdata[RATE_W-1:0];
               end
            end
            ADDR_VEL_CEIL: nxt_ceil = reg_wdata[CEIL_W-1:0];
            ADDR_VEL_FLOOR: begin
               if (running) begin
                  nxt_cmd_error = 1'b1;
               end else begin
                  nxt_floor = reg_wdata[FLOOR_VAL_W-1:0];
               end
            end
            ADDR_FS_THRESH: nxt_fs = reg_wdata[FS_W-1:0];
            default: begin
               torque_wr = is_torque_addr;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         elec_pos_ff <= RST_ELEC_POS;
         mark_ff <= RST_MARK;
         ramp_up_ff <= RST_RATE;
         ramp_down_ff <= RST_RATE;
         ceil_ff <= RST_VEL_CEIL;
         floor_ff <= RST_VEL_FLOOR;
         fs_ff <= RST_FS_THRESH;
         cmd_error_ff <= 1'b0;
         elec_load_ff <= 1'b0;
      end else begin
         elec_pos_ff <= nxt_elec_pos;
         mark_ff <= nxt_mark;
         ramp_up_ff <= nxt_ramp_up;
         ramp_down_ff <= nxt_ramp_down;
         ceil_ff <= nxt_ceil;
         floor_ff <= nxt_floor;
         fs_ff <= nxt_fs;
         cmd_error_ff <= nxt_cmd_error;
         elec_load_ff <= nxt_elec_load;
      end
   end

   assign pif.tick = tick_ff;
   assign pif.run_req = run_req;
   assign pif.ramp_up = ramp_up_ff;
   assign pif.ramp_down = ramp_down_ff;
   assign pif.ceiling = ceil_ff;
   assign pif.floor_val = floor_ff;

   // ***********************************************************
   // Torque reference store
   // ***********************************************************
   logic [TORQUE_W-1:0] torque_bus_data;
   logic [TORQUE_W-1:0] torque_live_data;

   torque_store #(
      .DEPTH(4),
      .WIDTH(TORQUE_W)
   ) u_torque (
      .mclk(mclk),
      .reset(reset),
      .wr_en(torque_wr),
      .wr_addr(torque_wr_idx),
      .wr_data(reg_wdata[TORQUE_W-1:0]),
      .rd_a_addr(torque_wr_idx),
      .rd_a_data(torque_bus_data),
      .rd_b_addr(pif.state),
      .rd_b_data(torque_live_data)
   );

   // ***********************************************************
   // Register reads
   // ***********************************************************
   // Two-cycle read: the torque store read data is itself registered
   logic rd_stage_ff, nxt_rd_stage;
   logic rd_torque_ff, nxt_rd_torque;
   logic [DATA_W-1:0] rd_hold_ff, nxt_rd_hold;
   logic [DATA_W-1:0] rdata_ff, nxt_rdata;
   logic rvalid_ff, nxt_rvalid;

   always_comb begin
      nxt_rd_stage = reg_rd;
      nxt_rd_torque = reg_rd && is_torque_addr;
      nxt_rd_hold = '0;
      case (reg_addr)
         ADDR_ELEC_POS: nxt_rd_hold = DATA_W'(elec_pos_ff);
         ADDR_MARK: nxt_rd_hold = mark_ff;
         ADDR_SPEED: nxt_rd_hold = DATA_W'(pif.speed);
         ADDR_RAMP_UP: nxt_rd_hold = DATA_W'(ramp_up_ff);
         ADDR_RAMP_DOWN: nxt_rd_hold = DATA_W'(ramp_down_ff);
         ADDR_VEL_CEIL: nxt_rd_hold = DATA_W'(ceil_ff);
         ADDR_VEL_FLOOR: nxt_rd_hold = DATA_W'({1'b0, floor_ff});
         ADDR_FS_THRESH: nxt_rd_hold = DATA_W'(fs_ff);
         default: nxt_rd_hold = '0;
      endcase
      nxt_rvalid = rd_stage_ff;
      nxt_rdata = rdata_ff;
      if (rd_stage_ff) begin
         nxt_rdata = rd_torque_ff ? DATA_W'(torque_bus_data) : rd_hold_ff;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         rd_stage_ff <= 1'b0;
         rd_torque_ff <= 1'b0;
         rd_hold_ff <= '0;
         rdata_ff <= '0;
         rvalid_ff <= 1'b0;
      end else begin
         rd_stage_ff <= nxt_rd_stage;
         rd_torque_ff <= nxt_rd_torque;
         rd_hold_ff <= nxt_rd_hold;
         rdata_ff <= nxt_rdata;
         rvalid_ff <= nxt_rvalid;
      end
   end

   // ***********************************************************
   // Drive mode outputs
   // ***********************************************************
   logic fs_ff_out, nxt_fs_out;
   logic boost_ff, nxt_boost;
   logic [SPEED_W-1:0] speed_out_ff, nxt_speed_out;
   logic [1:0] state_out_ff, nxt_state_out;
   logic [SPEED_W:0] fs_limit;

   always_comb begin
      // Half count added so a zero code still leaves a low microstep band
      fs_limit = (SPEED_W+1)'({fs_ff[FS_VAL_W-1:0], CEIL_SHIFT'(0)}) + (SPEED_W+1)'(FS_HALF_COUNT);
      // Strictly above: at the top code the ceiling can never pass it
      nxt_fs_out = ({1'b0, pif.speed} > fs_limit);
      nxt_boost = fs_ff[FS_BOOST_BIT];
      nxt_speed_out = pif.speed;
      nxt_state_out = pif.state;
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         fs_ff_out <= 1'b0;
         boost_ff <= 1'b0;
         speed_out_ff <= '0;
         state_out_ff <= '0;
      end else begin
         fs_ff_out <= nxt_fs_out;
         boost_ff <= nxt_boost;
         speed_out_ff <= nxt_speed_out;
         state_out_ff <= nxt_state_out;
      end
   end

   assign reg_rdata = rdata_ff;
   assign reg_rvalid = rvalid_ff;
   assign cmd_error = cmd_error_ff;
   assign electrical_position = elec_pos_ff;
   assign elec_pos_load = elec_load_ff;
   assign current_velocity = speed_out_ff;
   assign motion_state = state_out_ff;
   assign full_step_drive = fs_ff_out;
   assign boost_drive = boost_ff;
   assign torque_ref = torque_live_data;

endmodule
`default_nettype wire

// >>> tb/motion_regs_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module motion_regs_asserts
   import motion_regs_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic cmd_error,
   input wire logic run_req,
   input wire logic ustep_adv,
   input wire logic ustep_dir,
   input wire logic [ELEC_W-1:0] electrical_position,
   input wire logic elec_pos_load,
   input wire logic [SPEED_W-1:0] current_velocity,
   input wire logic [1:0] motion_state,
   input wire logic full_step_drive,
   input wire logic boost_drive,
   input wire logic [TORQUE_W-1:0] torque_ref
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);
   logic [CEIL_W-1:0] ceil_ff;
   logic [2:0] quiet_ff;
   logic [FS_VAL_W-1:0] fs_sh_ff;
   // Threshold shadow for the full-step compare
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         fs_sh_ff <= RST_FS_THRESH[FS_VAL_W-1:0];
      end else if (reg_wr && reg_addr == ADDR_FS_THRESH) begin
         fs_sh_ff <= reg_wdata[FS_VAL_W-1:0];
      end
   end
   // Ceiling shadow; the clamp lags a write by a few cycles, so checking pauses
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         ceil_ff <= RST_VEL_CEIL;
         quiet_ff <= 3'h0;
      end else if (reg_wr && reg_addr == ADDR_VEL_CEIL) begin
         ceil_ff <= reg_wdata[CEIL_W-1:0];
         quiet_ff <= 3'h4;
      end else if (quiet_ff != 3'h0) begin
         quiet_ff <= quiet_ff - 3'h1;
      end
   end
   vel_write_err_a: assert property (reg_wr && reg_addr == ADDR_SPEED |=> cmd_error)
      else $error("velocity write did not raise cmd_error");
   // State output lags the internal state one cycle, so it is read one cycle after the write
   ws_write_refused_a: assert property (reg_wr && (reg_addr == ADDR_ELEC_POS || reg_addr == ADDR_RAMP_UP ||
      reg_addr == ADDR_RAMP_DOWN) |=> (motion_state != MOT_STOPPED) ? (cmd_error && !elec_pos_load) : !cmd_error)
      else $error("write while running was not refused");
   floor_run_err_a: assert property (reg_wr && reg_addr == ADDR_VEL_FLOOR |=>
      cmd_error == (motion_state != MOT_STOPPED))
      else $error("floor write while running gave no error");
   elec_pos_take_a: assert property (reg_wr && reg_addr == ADDR_ELEC_POS && motion_state == MOT_STOPPED &&
      !run_req && !$past(run_req) |=> elec_pos_load && !cmd_error && electrical_position == $past(reg_wdata[8:0]))
      else $error("position write not imposed at once");
   ustep_move_a: assert property (ustep_adv && !(reg_wr && reg_addr == ADDR_ELEC_POS) |=>
      electrical_position == $past(electrical_position) + ($past(ustep_dir) ? ELEC_USTEP_INC : -ELEC_USTEP_INC))
      else $error("microstep advance wrong");
   floor_read_a: assert property (reg_rd && reg_addr == ADDR_VEL_FLOOR |-> ##2 reg_rvalid && reg_rdata[21:12] == '0)
      else $error("floor read shows upper bits");
   boost_copy_a: assert property (reg_wr && reg_addr == ADDR_FS_THRESH |-> ##2 boost_drive == $past(reg_wdata[10], 2))
      else $error("boost output does not follow threshold bit");
   full_step_gate_a: assert property (full_step_drive ==
      (current_velocity > {$past(fs_sh_ff), 10'h000} + 20'h00200))
      else $error("full step drive below threshold speed");
   vel_ceiling_a: assert property (quiet_ff == 3'h0 |-> current_velocity <= {ceil_ff, 10'h000})
      else $error("velocity above ceiling");
   accel_seen_c: cover property (motion_state == MOT_ACCEL && torque_ref != 7'h00);
   cruise_seen_c: cover property (motion_state == MOT_CRUISE && full_step_drive);
   decel_seen_c: cover property (motion_state == MOT_DECEL);
endmodule
bind stepper_motion_profile_regs motion_regs_asserts chk (.mclk(mclk), .reset(reset), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
   .cmd_error(cmd_error), .run_req(run_req), .ustep_adv(ustep_adv), .ustep_dir(ustep_dir),
   .electrical_position(electrical_position), .elec_pos_load(elec_pos_load), .current_velocity(current_velocity),
   .motion_state(motion_state), .full_step_drive(full_step_drive), .boost_drive(boost_drive), .torque_ref(torque_ref));
`default_nettype wire

// >>> tb/host_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_model
   import motion_regs_pkg::*;
(
   input wire logic mclk,
   output logic reg_wr,
   output logic reg_rd,
   output logic [ADDR_W-1:0] reg_addr,
   output logic [DATA_W-1:0] reg_wdata,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic cmd_error
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 5'h1F;
      reg_wdata = 22'h2AAAAA;
   end
   // Released address and data are inverted so stale values never repeat the last access
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, output logic err);
      if (a == ADDR_ELEC_POS) d[2:0] = 3'h0;
      if (a == ADDR_RAMP_UP && d[11:0] == 12'hFFF) d[0] = 1'b0;
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
      #1;
      err = cmd_error;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] q);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      @(posedge mclk);
      #1;
      q = reg_rvalid ? reg_rdata : 'x;
   endtask
endmodule
`default_nettype wire

// >>> tb/stepper_motion_profile_regs_bench.sv
`timescale 1ns/10ps
`default_nettype none
module stepper_motion_profile_regs_bench;
   import motion_regs_pkg::*;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic reg_wr, reg_rd, reg_rvalid, cmd_error, elec_pos_load, full_step_drive, boost_drive;
   logic run_req = 1'b0;
   logic ustep_adv = 1'b0;
   logic ustep_dir = 1'b1;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata, reg_rdata;
   logic [ELEC_W-1:0] electrical_position;
   logic [SPEED_W-1:0] current_velocity;
   logic [1:0] motion_state;
   logic [TORQUE_W-1:0] torque_ref;
   int err_total = 0;
   int n_compared = 0;
   int cyc = 0;
   logic [ADDR_W-1:0] ra [13] = '{5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C,
      5'h15, 5'h0D};
   logic [DATA_W-1:0] rv [13] = '{22'h0, 22'h0, 22'h0, 22'h08A, 22'h08A, 22'h041, 22'h0, 22'h29, 22'h29, 22'h29,
      22'h29, 22'h027, 22'h0};
   logic [ADDR_W-1:0] ws [4] = '{5'h02, 5'h05, 5'h06, 5'h08};
   logic [DATA_W-1:0] wv [4] = '{22'h1F8, 22'hFFE, 22'hFFE, 22'hFFF};
   always #12.5 mclk = ~mclk;
   host_model host (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .cmd_error(cmd_error));
   stepper_motion_profile_regs dut (.mclk(mclk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .cmd_error(cmd_error), .run_req(run_req), .ustep_adv(ustep_adv), .ustep_dir(ustep_dir),
      .electrical_position(electrical_position), .elec_pos_load(elec_pos_load), .current_velocity(current_velocity),
      .motion_state(motion_state), .full_step_drive(full_step_drive), .boost_drive(boost_drive),
      .torque_ref(torque_ref));
   // *****************
   // Checking tasks
   // *****************
   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      logic [DATA_W-1:0] q;
      host.rd(a, q);
      check($sformatf("register %h", a), exp, q);
   endtask
   task automatic wchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic exp_err);
      logic err;
      host.wr(a, d, err);
      check($sformatf("write error %h", a), exp_err, err);
   endtask
   // Torque follows the internal state one cycle late, as motion_state does, so three cycles are allowed
   task automatic wait_state(input motion_e s, input logic [TORQUE_W-1:0] tq);
      int n;
      n = 0;
      while (motion_state !== s && n < 3000) begin
         @(posedge mclk);
         #1;
         n++;
      end
      repeat (3) @(posedge mclk);
      #1;
      check("motion state", s, motion_state);
      check("torque level", tq, torque_ref);
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         report_and_stop();
      end
   end
   // *****************
   // Main sequence
   // *****************
   initial begin
      repeat (16) @(posedge mclk);
      reset <= 1'b0;
      for (int i = 0; i < 13; i++) rchk(ra[i], rv[i]);
      wchk(ADDR_ELEC_POS, 22'h1FF, 1'b0);
      check("electrical position", 22'h1F8, electrical_position);
      @(posedge mclk);
      ustep_adv <= 1'b1;
      @(posedge mclk);
      ustep_adv <= 1'b0;
      #1;
      check("position wrap", 22'h000, electrical_position);
      @(posedge mclk);
      ustep_dir <= 1'b0;
      ustep_adv <= 1'b1;
      @(posedge mclk);
      ustep_adv <= 1'b0;
      #1;
      check("position back", 22'h1F8, electrical_position);
      wchk(ADDR_MARK, 22'h200000, 1'b0);
      rchk(ADDR_MARK, 22'h200000);
      wchk(ADDR_SPEED, 22'h3FFFF, 1'b1);
      rchk(ADDR_SPEED, 22'h0);
      wchk(ADDR_RAMP_UP, 22'hFFE, 1'b0);
      wchk(ADDR_RAMP_DOWN, 22'hFFE, 1'b0);
      wchk(ADDR_VEL_FLOOR, 22'h1FFF, 1'b0);
      rchk(ADDR_VEL_FLOOR, 22'h0FFF);
      wchk(ADDR_VEL_CEIL, 22'h040, 1'b0);
      wchk(ADDR_FS_THRESH, 22'h400, 1'b0);
      rchk(ADDR_FS_THRESH, 22'h400);
      check("boost", 22'h1, boost_drive);
      for (int i = 0; i < 4; i++) wchk(ADDR_TORQUE_FIRST + 5'(i), 22'h10 + 22'(i), 1'b0);
      check("torque at rest", 22'h10, torque_ref);
      @(posedge mclk);
      run_req <= 1'b1;
      wait_state(MOT_ACCEL, 7'h12);
      for (int i = 0; i < 4; i++) wchk(ws[i], 22'h0AA5, 1'b1);
      wchk(ADDR_MARK, 22'h000123, 1'b0);
      wchk(ADDR_VEL_CEIL, 22'h040, 1'b0);
      wait_state(MOT_CRUISE, 7'h11);
      check("cruise velocity", 22'h10000, current_velocity);
      check("full step", 22'h1, full_step_drive);
      wchk(ADDR_FS_THRESH, 22'h3FF, 1'b0);
      rchk(ADDR_FS_THRESH, 22'h3FF);
      check("full step max", 22'h0, full_step_drive);
      check("boost off", 22'h0, boost_drive);
      @(posedge mclk);
      run_req <= 1'b0;
      wait_state(MOT_DECEL, 7'h13);
      wait_state(MOT_STOPPED, 7'h10);
      check("stopped velocity", 22'h0, current_velocity);
      for (int i = 0; i < 4; i++) rchk(ws[i], wv[i]);
      rchk(ADDR_MARK, 22'h000123);
      report_and_stop();
   end
endmodule
`default_nettype wire
